// file: snp_core.sv
// Serial command decode, write latch, status register and block protection
//
// Notes on behaviour
// - Mode 0 or 3, decided at select fall
// - First bit on first rising clock edge
// - Sample on rise, drive output on fall
// - Bytes of eight bits, MSB first
// - First byte is opcode, rest operands
// - Decode latch set and clear, no operands
// - Decode status read and write, one byte
// - Decode memory read and write with address
// - Latch clear after reset
// - Set command sets latch, flag mirrors it
// - Any completed write clears the latch
// - Clear command clears latch
// - Status read shifts out status byte
// - Status bit layout, fixed zero bits
// - Status write leaves latch flag alone
// - Guard pair selects protected range
// - Guard pin refuses status writes if enabled
// - Array write needs latch, unprotected address
// - Fifteen address bits, top bit ignored
// - Address increments, wraps to zero
// - Byte committed at eighth bit, select ends
// - Pause pin suspends while clock low
`default_nettype none
module snp_core
    import snp_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Serial pins
    input  wire logic        sel_pin_n,
    input  wire logic        sclk_pin,
    input  wire logic        sdi_pin,
    input  wire logic        pause_pin_n,
    input  wire logic        write_guard_pin_n,
    output logic             sdo_out,
    output logic             sdo_oe_n,
    // Memory array side
    output logic             mem_we,
    output logic             mem_re,
    output logic [14:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    // Observed state
    output logic             idle_high_mode
);
    logic [1:0]  sel_sync, clk_sync, dat_sync, pause_sync, guard_sync;
    logic        clk_prev, sel_prev;
    logic        pause_n_q;
    logic [2:0]  bit_cnt;
    logic [7:0]  shift_in;
    logic [7:0]  shift_out;
    logic [1:0]  addr_cnt;
    logic [14:0] addr;
    logic        is_write;
    logic        is_read;
    logic        latch;
    logic        pin_guard_enable, block_guard_hi, block_guard_lo;
    logic        guard_low_at_sel;
    snp_state_t  state;

    // Two flops on every pin before any logic reads it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_sync   <= 2'h3;
            clk_sync   <= 2'h0;
            dat_sync   <= 2'h0;
            pause_sync <= 2'h3;
            guard_sync <= 2'h3;
        end else begin
            sel_sync   <= {sel_sync[0], sel_pin_n};
            clk_sync   <= {clk_sync[0], sclk_pin};
            dat_sync   <= {dat_sync[0], sdi_pin};
            pause_sync <= {pause_sync[0], pause_pin_n};
            guard_sync <= {guard_sync[0], write_guard_pin_n};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev <= 1'b0;
            sel_prev <= 1'b1;
        end else begin
            clk_prev <= clk_sync[1];
            sel_prev <= sel_sync[1];
        end
    end

    // Pause only changes while the clock is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pause_n_q <= 1'b1;
        end else if (!clk_sync[1]) begin
            pause_n_q <= pause_sync[1];
        end
    end

    logic sel_fall, sel_rise, active, clk_rise, clk_fall;
    assign sel_fall = sel_prev && !sel_sync[1] && pause_n_q;
    assign sel_rise = !sel_prev && sel_sync[1] && pause_n_q;
    assign active   = !sel_sync[1] && !sel_prev;
    assign clk_rise = active && pause_n_q && clk_sync[1] && !clk_prev;
    assign clk_fall = active && pause_n_q && !clk_sync[1] && clk_prev;

    logic [7:0] next_byte;
    logic       byte_done;
    assign next_byte = {shift_in[6:0], dat_sync[1]};
    assign byte_done = clk_rise && (bit_cnt == BIT_LAST);

    logic [7:0] status_byte;
    assign status_byte = {pin_guard_enable, 3'h0, block_guard_hi, block_guard_lo, latch, 1'b0};

    // Mode is the clock level seen as select falls
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idle_high_mode   <= 1'b0;
            guard_low_at_sel <= 1'b0;
        end else if (sel_fall) begin
            idle_high_mode   <= clk_sync[1];
            guard_low_at_sel <= !guard_sync[1];
        end
    end

    // Bit counter restarts at select, so the first rise is bit 7
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt  <= 3'h0;
            shift_in <= 8'h00;
        end else if (sel_fall) begin
            bit_cnt  <= 3'h0;
            shift_in <= 8'h00;
        end else if (clk_rise) begin
            bit_cnt  <= bit_cnt + 3'h1;
            shift_in <= next_byte;
        end
    end

    logic protected_hit;
    always_comb begin
        unique case ({block_guard_hi, block_guard_lo})
            2'b00: protected_hit = 1'b0;
            2'b01: protected_hit = (addr >= ADDR_QUARTER);
            2'b10: protected_hit = (addr >= ADDR_HALF);
            2'b11: protected_hit = 1'b1;
        endcase
    end

    logic status_wr_ok;
    // Guard sampled at select fall, so mid-command changes wait
    assign status_wr_ok = latch && !(pin_guard_enable && guard_low_at_sel);

    // Command sequencer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= SNP_OPCODE;
            addr_cnt <= 2'h0;
            is_write <= 1'b0;
            is_read  <= 1'b0;
        end else if (sel_fall || sel_rise) begin
            state    <= SNP_OPCODE;
            addr_cnt <= 2'h0;
            is_write <= 1'b0;
            is_read  <= 1'b0;
        end else if (byte_done) begin
            unique case (state)
                SNP_OPCODE: begin
                    unique case (next_byte)
                        OP_MEM_RD:      begin state <= SNP_ADDR; is_read <= 1'b1; end
                        OP_MEM_WR:      begin state <= SNP_ADDR; is_write <= 1'b1; end
                        OP_STATUS_RD:   state <= SNP_STATUS;
                        OP_STATUS_WR:   begin state <= SNP_STATUS; is_write <= 1'b1; end
                        default:        state <= SNP_IGNORE;
                    endcase
                end
                SNP_ADDR: begin
                    addr_cnt <= addr_cnt + 2'h1;
                    if (addr_cnt + 2'h1 == ADDR_BYTES) begin
                        state <= SNP_DATA;
                    end
                end
                SNP_DATA:   state <= SNP_DATA;
                SNP_STATUS: state <= SNP_IGNORE;
                SNP_IGNORE: state <= SNP_IGNORE;
                default:    state <= SNP_IGNORE;
            endcase
        end
    end

    // Address capture and advance
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr <= ADDR_FIRST;
        end else if (byte_done && state == SNP_ADDR) begin
            addr <= {addr[6:0], next_byte};
        end else if (byte_done && state == SNP_DATA) begin
            addr <= (addr == ADDR_LAST) ? ADDR_FIRST : addr + 15'h0001;
        end
    end

    // Write latch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latch <= 1'b0;
        end else if (byte_done && state == SNP_OPCODE && next_byte == OP_SET_LATCH) begin
            latch <= 1'b1;
        end else if (byte_done && state == SNP_OPCODE && next_byte == OP_CLEAR_LATCH) begin
            latch <= 1'b0;
        end else if (sel_rise && is_write && (state == SNP_DATA || state == SNP_IGNORE)) begin
            latch <= 1'b0;
        end
    end

    // Status register; guard pair would sit in nonvolatile cells
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_guard_enable <= STATUS_RESET[BIT_PIN_GUARD];
            block_guard_hi   <= STATUS_RESET[BIT_GUARD_HI];
            block_guard_lo   <= STATUS_RESET[BIT_GUARD_LO];
        end else if (byte_done && state == SNP_STATUS && is_write && status_wr_ok) begin
            pin_guard_enable <= next_byte[BIT_PIN_GUARD];
            block_guard_hi   <= next_byte[BIT_GUARD_HI];
            block_guard_lo   <= next_byte[BIT_GUARD_LO];
        end
    end

    // Array write strobe at the eighth bit of each data byte
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_we    <= 1'b0;
            mem_wdata <= 8'h00;
            mem_addr  <= ADDR_FIRST;
            mem_re    <= 1'b0;
        end else begin
            mem_we    <= byte_done && state == SNP_DATA && is_write && latch && !protected_hit;
            mem_wdata <= next_byte;
            mem_addr  <= addr;
            mem_re    <= is_read && (state == SNP_DATA) && (bit_cnt == 3'h0) && clk_fall;
        end
    end

    // Output shifter; read data loaded on the first fall of each byte
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_out <= 8'h00;
            sdo_out   <= 1'b0;
            sdo_oe_n  <= 1'b1;
        end else if (!active || !pause_n_q) begin
            sdo_oe_n  <= 1'b1;
        end else if (clk_fall) begin
            if (state == SNP_STATUS && !is_write && bit_cnt == 3'h0) begin
                sdo_out   <= status_byte[7];
                shift_out <= {status_byte[6:0], 1'b0};
                sdo_oe_n  <= 1'b0;
            end else if (state == SNP_DATA && is_read && bit_cnt == 3'h0) begin
                sdo_out   <= mem_rdata[7];
                shift_out <= {mem_rdata[6:0], 1'b0};
                sdo_oe_n  <= 1'b0;
            end else if ((state == SNP_DATA && is_read) || (state == SNP_STATUS && !is_write)) begin
                sdo_out   <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'b0};
                sdo_oe_n  <= 1'b0;
            end else begin
                sdo_oe_n  <= 1'b1;
            end
        end
    end

    AST_LATCH_SET: assert property (@(posedge mclk) disable iff (!rst_n)
        (byte_done && state == SNP_OPCODE && next_byte == OP_SET_LATCH) |=> latch)
        else $error("latch not set after set command");
    AST_LATCH_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
        (byte_done && state == SNP_OPCODE && next_byte == OP_CLEAR_LATCH) |=> !latch)
        else $error("latch not cleared after clear command");
    AST_WRITE_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
        (sel_rise && is_write && state == SNP_DATA) |=> !latch)
        else $error("latch survives completed write");
    AST_STATUS_WR_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
        (sel_rise && is_write && state == SNP_IGNORE) |=> !latch)
        else $error("latch survives completed status write");
    AST_ZERO_BITS: assert property (@(posedge mclk) disable iff (!rst_n)
        status_byte[6:4] == 3'h0 && !status_byte[0])
        else $error("fixed status bits not zero");
    AST_NO_WE_LOCKED: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_we |-> $past(latch) && !$past(protected_hit))
        else $error("array write without latch or in protected range");
    AST_WE_FROM_DATA: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_we |-> $past(byte_done) && $past(is_write))
        else $error("array write strobe outside a data byte");

    // Half and quarter checks use the strobe's own address, not the range decoder; the whole array check uses no address
    AST_FULL_GUARD: assert property (@(posedge mclk) disable iff (!rst_n)
        (block_guard_hi && block_guard_lo) |=> !mem_we)
        else $error("whole array guard lets address through");
    AST_HALF_GUARD: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_we |-> !($past(block_guard_hi) && mem_addr >= ADDR_HALF))
        else $error("array write inside guarded upper half");
    AST_QUARTER_GUARD: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_we |-> !($past(block_guard_lo) && mem_addr >= ADDR_QUARTER))
        else $error("array write inside guarded upper quarter");
    AST_GUARD_PIN: assert property (@(posedge mclk) disable iff (!rst_n)
        (byte_done && state == SNP_STATUS && is_write && pin_guard_enable && guard_low_at_sel)
        |=> $stable({pin_guard_enable, block_guard_hi, block_guard_lo}))
        else $error("guarded status write changed bits");
    AST_STATUS_KEEPS_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
        (byte_done && state == SNP_STATUS && is_write) |=> latch == $past(latch))
        else $error("status write changed latch");
    AST_WRAP: assert property (@(posedge mclk) disable iff (!rst_n)
        (byte_done && state == SNP_DATA && addr == ADDR_LAST) |=> addr == ADDR_FIRST)
        else $error("address did not wrap");
    AST_OPCODE_RESTART: assert property (@(posedge mclk) disable iff (!rst_n)
        sel_fall |=> state == SNP_OPCODE && bit_cnt == 3'h0)
        else $error("select fall did not restart framing");
    AST_MODE_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_n)
        sel_fall |=> idle_high_mode == $past(clk_sync[1]))
        else $error("mode not taken from clock level at select fall");

    // Drive checks look one edge after the fall that loads the shifter; quiet checks look one edge after their trigger
    AST_STATUS_DRIVE: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_fall && state == SNP_STATUS && !is_write && bit_cnt == 3'h0)
        |=> !sdo_oe_n && sdo_out == $past(status_byte[7]))
        else $error("status read did not drive its first bit");
    AST_READ_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_fall && state == SNP_DATA && is_read && bit_cnt == 3'h0)
        |=> !sdo_oe_n && sdo_out == $past(mem_rdata[7]))
        else $error("memory read did not drive its first bit");
    AST_UNKNOWN_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_fall && state == SNP_IGNORE) |=> sdo_oe_n)
        else $error("output driven after an ignored command");
    AST_PAUSE_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
        !pause_n_q |=> sdo_oe_n)
        else $error("output driven while paused");
    AST_DESELECT_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
        !active |=> sdo_oe_n)
        else $error("output driven while deselected");
endmodule : snp_core
`default_nettype wire

// file: snp_pkg.sv
// Constants for the serial nonvolatile command and protection front end
`default_nettype none
package snp_pkg;
    localparam logic [7:0]  OP_SET_LATCH   = 8'h06;
    localparam logic [7:0]  OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0]  OP_STATUS_RD   = 8'h05;
    localparam logic [7:0]  OP_STATUS_WR   = 8'h01;
    localparam logic [7:0]  OP_MEM_RD      = 8'h03;
    localparam logic [7:0]  OP_MEM_WR      = 8'h02;
    localparam int          BIT_PIN_GUARD  = 7;
    localparam int          BIT_GUARD_HI   = 3;
    localparam int          BIT_GUARD_LO   = 2;
    localparam int          BIT_LATCH      = 1;
    localparam logic [14:0] ADDR_QUARTER   = 15'h6000;
    localparam logic [14:0] ADDR_HALF      = 15'h4000;
    localparam logic [14:0] ADDR_LAST      = 15'h7FFF;
    localparam logic [14:0] ADDR_FIRST     = 15'h0000;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [1:0]  ADDR_BYTES     = 2'h2;
    localparam logic [7:0]  STATUS_RESET   = 8'h00;
    typedef enum logic [2:0] {
        SNP_OPCODE  = 3'b000,
        SNP_ADDR    = 3'b001,
        SNP_DATA    = 3'b011,
        SNP_STATUS  = 3'b010,
        SNP_IGNORE  = 3'b110
    } snp_state_t;
endpackage : snp_pkg
`default_nettype wire

// file: snp_spi_master.sv
// SPI bus master model for the serial command front end
`default_nettype none
module snp_spi_master (
    // Clock
    input  wire logic mclk,
    // Serial pins
    output logic      sel_pin_n,
    output logic      sclk_pin,
    output logic      sdi_pin,
    input  wire logic sdo_out,
    input  wire logic sdo_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mode3;
    logic drove;
    initial begin
        sel_pin_n = 1'b1;
        sclk_pin  = 1'b0;
        sdi_pin   = 1'b0;
        mode3     = 1'b0;
        drove     = 1'b0;
    end
    // Select falls with the clock at the idle level of the mode
    task automatic start(input logic m3);
        @(posedge mclk);
        mode3    <= m3;
        sclk_pin <= m3;
        repeat (4) @(posedge mclk);
        sel_pin_n <= 1'b0;
        drove = 1'b0;
        repeat (4) @(posedge mclk);
    endtask : start
    // Read bit taken late in the high phase, well clear of the output change
    task automatic xfer(input logic [7:0] dout, output logic [7:0] din);
        for (int i = 7; i >= 0; i--) begin
            sclk_pin <= 1'b0;
            sdi_pin  <= dout[i];
            repeat (4) @(posedge mclk);
            sclk_pin <= 1'b1;
            repeat (4) @(posedge mclk);
            din[i] = sdo_out;
            if (sdo_oe_n === 1'b0) drove = 1'b1;
        end
    endtask : xfer
    // Clock pulses sent while held; ends low so the pause may lift
    task automatic pulse(input int n);
        repeat (n) begin
            sclk_pin <= 1'b1;
            sdi_pin  <= 1'b1;
            repeat (4) @(posedge mclk);
            sclk_pin <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask : pulse
    // Idle data line flips so a stale bit is never mistaken for a live one
    task automatic stop();
        sclk_pin <= mode3;
        repeat (4) @(posedge mclk);
        sel_pin_n <= 1'b1;
        sdi_pin   <= ~sdi_pin;
        repeat (8) @(posedge mclk);
    endtask : stop
endmodule : snp_spi_master
`default_nettype wire

// file: spi_nvram_command_protect_tb.sv
// Self-checking bench for the serial command and protection front end
`default_nettype none
module spi_nvram_command_protect_tb;
    import snp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk;
    logic        rst_n;
    logic        pause_pin_n;
    logic        write_guard_pin_n;
    logic        sel_pin_n;
    logic        sclk_pin;
    logic        sdi_pin;
    logic        sdo_out;
    logic        sdo_oe_n;
    logic        mem_we;
    logic        idle_high_mode;
    logic [14:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic [7:0]  mem [0:32767];
    logic [7:0]  st;
    logic [7:0]  r0;
    logic [7:0]  r1;
    int          err_count = 0;
    int          n_tests = 0;
    int          n_we = 0;
    int          cyc = 0;
    int          w0;
    snp_core uut (.mclk(mclk), .rst_n(rst_n), .sel_pin_n(sel_pin_n), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
        .pause_pin_n(pause_pin_n), .write_guard_pin_n(write_guard_pin_n), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n), .mem_we(mem_we), .mem_re(), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .idle_high_mode(idle_high_mode));
    snp_spi_master m (.mclk(mclk), .sel_pin_n(sel_pin_n), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));
    assign mem_rdata = mem[mem_addr];
    always @(posedge mclk) begin
        if (mem_we === 1'b1) begin
            mem[mem_addr] <= mem_wdata;
            n_we <= n_we + 1;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic cmd1(input logic [7:0] op, input logic m3);
        logic [7:0] d;
        m.start(m3);
        m.xfer(op, d);
        m.stop();
    endtask : cmd1
    task automatic rd_st(input logic m3, output logic [7:0] s);
        logic [7:0] d;
        m.start(m3);
        m.xfer(OP_STATUS_RD, d);
        m.xfer(8'h00, s);
        m.stop();
    endtask : rd_st
    task automatic wr_st(input logic [7:0] v);
        logic [7:0] d;
        cmd1(OP_SET_LATCH, 1'b0);
        m.start(1'b0);
        m.xfer(OP_STATUS_WR, d);
        m.xfer(v, d);
        m.stop();
    endtask : wr_st
    // Address high byte carries a set top bit that must be ignored
    task automatic mem_cmd(input logic [7:0] op, input logic [14:0] a, input logic [7:0] d0,
                           input logic [7:0] d1, output logic [7:0] q0, output logic [7:0] q1);
        logic [7:0] d;
        m.start(1'b0);
        m.xfer(op, d);
        m.xfer({1'b1, a[14:8]}, d);
        m.xfer(a[7:0], d);
        m.xfer(d0, q0);
        m.xfer(d1, q1);
        m.stop();
    endtask : mem_cmd
    task automatic t_latch();
        rd_st(1'b0, st);
        chk(st, STATUS_RESET);
        chk(idle_high_mode, 1'b0);
        cmd1(OP_SET_LATCH, 1'b1);
        rd_st(1'b1, st);
        chk(st, 8'h02);
        chk(idle_high_mode, 1'b1);
        cmd1(OP_CLEAR_LATCH, 1'b0);
        rd_st(1'b0, st);
        chk(st, 8'h00);
        $display("latch test done");
    endtask : t_latch
    task automatic t_status();
        wr_st(8'hFF);
        rd_st(1'b0, st);
        chk(st, 8'h8C);
        write_guard_pin_n <= 1'b0;
        wr_st(8'h00);
        rd_st(1'b0, st);
        chk(st, 8'h8C);
        write_guard_pin_n <= 1'b1;
        wr_st(8'h04);
        rd_st(1'b0, st);
        chk(st, 8'h04);
        $display("status test done");
    endtask : t_status
    task automatic t_mem();
        w0 = n_we;
        mem_cmd(OP_MEM_WR, 15'h5FFF, 8'hA1, 8'hB2, r0, r1);
        chk(n_we - w0, 0);
        cmd1(OP_SET_LATCH, 1'b0);
        mem_cmd(OP_MEM_WR, 15'h5FFF, 8'hA1, 8'hB2, r0, r1);
        chk(n_we - w0, 1);
        chk(mem[15'h5FFF], 8'hA1);
        chk(mem[15'h6000], 8'h00);
        rd_st(1'b0, st);
        chk(st, 8'h04);
        mem[ADDR_LAST] = 8'h5A;
        mem[ADDR_FIRST] = 8'hC3;
        mem_cmd(OP_MEM_RD, ADDR_LAST, 8'h00, 8'h00, r0, r1);
        chk(r0, 8'h5A);
        chk(r1, 8'hC3);
        $display("memory test done");
    endtask : t_mem
    task automatic t_unknown();
        cmd1(OP_SET_LATCH, 1'b0);
        m.start(1'b0);
        m.xfer(8'hFF, r0);
        m.xfer(OP_STATUS_RD, r0);
        m.xfer(8'h00, r0);
        m.stop();
        chk(m.drove, 1'b0);
        rd_st(1'b0, st);
        chk(st, 8'h06);
        chk(m.drove, 1'b1);
        $display("unknown opcode test done");
    endtask : t_unknown
    // Clocks sent while paused must not shift the opcode framing
    task automatic t_pause();
        m.start(1'b0);
        pause_pin_n <= 1'b0;
        repeat (6) @(posedge mclk);
        m.pulse(3);
        chk(sdo_oe_n, 1'b1);
        pause_pin_n <= 1'b1;
        repeat (6) @(posedge mclk);
        m.xfer(OP_CLEAR_LATCH, r0);
        m.stop();
        rd_st(1'b0, st);
        chk(st, 8'h04);
        $display("pause test done");
    endtask : t_pause
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        rst_n = 1'b0;
        pause_pin_n = 1'b1;
        write_guard_pin_n = 1'b1;
        for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_latch();
        t_status();
        t_mem();
        t_unknown();
        t_pause();
        end_sim();
    end
endmodule : spi_nvram_command_protect_tb
`default_nettype wire
